// [include/pgc_pkg.sv]
`default_nettype none
package pgc_pkg;
    // Bus geometry
    localparam int unsigned ADDR_W = 14;
    localparam int unsigned NUM_SLOTS = 32;
    localparam int unsigned NUM_SPOOF = 5;
    // Register byte offsets
    localparam logic [13:0] OFF_GLOBAL = 14'h1000;
    localparam logic [13:0] OFF_SEED = 14'h1010;
    localparam logic [13:0] OFF_STATUS = 14'h1100;
    localparam logic [13:0] OFF_MASK = 14'h1104;
    localparam logic [13:0] OFF_CNT_CFG = 14'h1200;
    localparam logic [13:0] OFF_CNT_VAL = 14'h1300;
    // Slot index field inside a slot region, stride of eight bytes
    localparam logic [13:0] SLOT_IDX_MASK = 14'h00f8;
    localparam int unsigned SLOT_IDX_LSB = 3;
    // Global config field positions
    localparam int unsigned TX_FRAG_BIT = 11;
    localparam int unsigned RX_FRAG_BIT = 12;
    localparam int unsigned SPOOF_LSB = 24;
    // Counter config field positions
    localparam int unsigned CNT_EN_BIT = 0;
    localparam int unsigned CNT_DIR_BIT = 1;
    localparam int unsigned CNT_FN_BIT = 12;
    localparam logic [31:0] CNT_CFG_BITS = 32'h0000_1003;
    // Counter value layout
    localparam int unsigned LIMIT_LSB = 16;
    localparam logic [4:0] FILTER_BASE_MASK = 5'h1e;
    // Values after reset
    localparam logic [31:0] SEED_RESET = 32'h0000_00ff;
    localparam logic [4:0] SPOOF_RESET = 5'h00;

    // Per-slot binding
    typedef struct packed {
        logic fn;  // Filter index low bit
        logic dir; // One binds a transmit filter
        logic en;  // Counter enable
    } pgc_slot_cfg_t;

    // Transmit packet descriptor from the filter engine
    typedef struct packed {
        logic valid;
        logic fragment;
        logic [4:0] src_match; // Source IP equals filter k address
    } pgc_tx_pkt_t;

    // Receive packet descriptor
    typedef struct packed {
        logic valid;
        logic fragment;
    } pgc_rx_pkt_t;

    // Per-packet decisions
    typedef struct packed {
        logic tx_block;
        logic rx_block;
        logic spoof;
    } pgc_verdict_t;

    // State of one counter slot
    typedef struct packed {
        logic [15:0] limit;
        logic [15:0] count;
        logic hit;
    } pgc_slot_state_t;

    // State of the register bank
    typedef struct packed {
        logic tx_drop;
        logic rx_drop;
        logic [4:0] spoof_sel;
        logic [31:0] seed;
        logic [31:0] status;
        logic [31:0] mask;
        pgc_slot_cfg_t [NUM_SLOTS-1:0] slot_cfg;
        logic waitrequest;
        logic [31:0] rdata;
        logic irq;
        pgc_verdict_t verdict;
    } pgc_top_state_t;
endpackage
`default_nettype wire

// [design/pgc_counter_slot.sv]
`default_nettype none
module pgc_counter_slot #(
    parameter int unsigned INDEX = 0
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Binding and filter matches
    input wire pgc_pkg::pgc_slot_cfg_t cfg_i,
    input wire logic [31:0] tx_match_i,
    input wire logic [31:0] rx_match_i,
    // Software access to the value word
    input wire logic val_we_i,
    input wire logic [31:0] val_wdata_i,
    // Readback and threshold event
    output logic [31:0] value_o,
    output logic hit_o
);
    // Base filter of this slot pair, low bit cleared
    localparam logic [4:0] BASE = 5'(INDEX) & pgc_pkg::FILTER_BASE_MASK;

    pgc_pkg::pgc_slot_state_t q; // Registered state
    pgc_pkg::pgc_slot_state_t d; // Next state
    logic [4:0] filt; // Bound filter index
    logic match; // Bound filter matched a packet
    logic [15:0] inc; // Count plus one

    // Count matches, wrap at the limit and flag it
    always_comb begin
        filt = BASE + {4'h0, cfg_i.fn};
        match = cfg_i.dir ? tx_match_i[filt] : rx_match_i[filt];
        inc = q.count + 16'h0001;
        d = q;
        d.hit = 1'b0;
        if (val_we_i) begin
            // Software write wins over a match in the same cycle
            d.limit = val_wdata_i[31:pgc_pkg::LIMIT_LSB];
            d.count = val_wdata_i[15:0];
        end else if (cfg_i.en && match) begin
            if (inc == q.limit) begin
                d.count = 16'h0000;
                d.hit = 1'b1;
            end else begin
                d.count = inc;
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign value_o = {q.limit, q.count};
    assign hit_o = q.hit;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    a_hit_needs_en: assert property (hit_o |-> $past(cfg_i.en) && $past(match))
        else $error("hit without enabled match");
    a_hit_wraps: assert property (hit_o |-> q.count == 16'h0000 && !$past(val_we_i))
        else $error("hit without wrap to zero");
    a_count_step: assert property ((cfg_i.en && match && !val_we_i && inc != q.limit)
        |=> q.count == $past(inc))
        else $error("count did not advance by one");
    a_bind_index: assert property (filt[4:1] == BASE[4:1] && filt[0] == cfg_i.fn)
        else $error("wrong bound filter index");
endmodule // pgc_counter_slot
`default_nettype wire

// [design/pgc_top.sv]
`default_nettype none
module pgc_top (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Avalon-MM slave
    input wire logic [13:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Packet descriptors and filter matches
    input wire pgc_pkg::pgc_tx_pkt_t tx_pkt_i,
    input wire pgc_pkg::pgc_rx_pkt_t rx_pkt_i,
    input wire logic [31:0] tx_match_i,
    input wire logic [31:0] rx_match_i,
    // Decisions and configuration out
    output pgc_pkg::pgc_verdict_t verdict_o,
    output logic [31:0] hash_seed_o,
    // Interrupt
    output logic irq_o
);
    localparam int unsigned N = pgc_pkg::NUM_SLOTS;

    pgc_pkg::pgc_top_state_t q; // Registered state
    pgc_pkg::pgc_top_state_t d; // Next state

    logic [13:0] addr; // Word-aligned address
    logic [4:0] slot_idx; // Slot addressed
    logic in_cfg; // Address in slot config region
    logic in_val; // Address in slot value region
    logic wr_fire; // Write takes effect this edge
    logic [31:0] bmask; // Byte enables per bit
    logic [31:0] rd_mux; // Read data selected
    logic [31:0] cur; // Current word of the addressed register
    logic [31:0] merged; // Current word with written bytes
    logic [31:0] clr_vec; // Status bits cleared by software
    logic [31:0] hits; // Threshold events this cycle
    logic [31:0] keep_vec; // Status bits that must survive
    logic [N-1:0] val_we; // Value write per slot
    logic [31:0] slot_val [N]; // Slot value readback
    pgc_pkg::pgc_slot_cfg_t wd_cfg; // Slot config from write data

    // Global config word as software sees it
    function automatic logic [31:0] global_word(input pgc_pkg::pgc_top_state_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[pgc_pkg::TX_FRAG_BIT] = s.tx_drop;
        w[pgc_pkg::RX_FRAG_BIT] = s.rx_drop;
        w[pgc_pkg::SPOOF_LSB +: pgc_pkg::NUM_SPOOF] = s.spoof_sel;
        return w;
    endfunction

    // Slot config word, reserved bits zero
    function automatic logic [31:0] cfg_word(input pgc_pkg::pgc_slot_cfg_t c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[pgc_pkg::CNT_EN_BIT] = c.en;
        w[pgc_pkg::CNT_DIR_BIT] = c.dir;
        w[pgc_pkg::CNT_FN_BIT] = c.fn;
        return w;
    endfunction

    // One counter slot per entry
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_slot
            pgc_counter_slot #(
                .INDEX(gi)
            ) u_slot (
                .sys_clk_i(sys_clk_i),
                .reset_i(reset_i),
                .cfg_i(q.slot_cfg[gi]),
                .tx_match_i(tx_match_i),
                .rx_match_i(rx_match_i),
                .val_we_i(val_we[gi]),
                .val_wdata_i(merged),
                .value_o(slot_val[gi]),
                .hit_o(hits[gi])
            );
        end
    endgenerate

    // Address decode and read mux
    always_comb begin
        addr = {avs_address_i[13:2], 2'b00};
        slot_idx = addr[pgc_pkg::SLOT_IDX_LSB +: 5];
        in_cfg = (addr & ~pgc_pkg::SLOT_IDX_MASK) == pgc_pkg::OFF_CNT_CFG;
        in_val = (addr & ~pgc_pkg::SLOT_IDX_MASK) == pgc_pkg::OFF_CNT_VAL;
        for (int b = 0; b < 4; b++) begin
            bmask[8*b +: 8] = {8{avs_byteenable_i[b]}};
        end
        if (in_cfg) begin
            cur = cfg_word(q.slot_cfg[slot_idx]);
        end else if (in_val) begin
            cur = slot_val[slot_idx];
        end else if (addr == pgc_pkg::OFF_GLOBAL) begin
            cur = global_word(q);
        end else if (addr == pgc_pkg::OFF_SEED) begin
            cur = q.seed;
        end else if (addr == pgc_pkg::OFF_STATUS) begin
            cur = q.status;
        end else if (addr == pgc_pkg::OFF_MASK) begin
            cur = q.mask;
        end else begin
            // Unmapped word reads as zero
            cur = 32'h0000_0000;
        end
        rd_mux = cur;
        merged = (cur & ~bmask) | (avs_writedata_i & bmask);
        wd_cfg.en = merged[pgc_pkg::CNT_EN_BIT];
        wd_cfg.dir = merged[pgc_pkg::CNT_DIR_BIT];
        wd_cfg.fn = merged[pgc_pkg::CNT_FN_BIT];
    end

    // Write strobes; a write lands on the edge that raises waitrequest again
    always_comb begin
        wr_fire = avs_write_i && !q.waitrequest;
        val_we = '0;
        if (wr_fire && in_val) begin
            val_we[slot_idx] = 1'b1;
        end
        clr_vec = 32'h0000_0000;
        if (wr_fire && addr == pgc_pkg::OFF_STATUS) begin
            clr_vec = avs_writedata_i & bmask;
        end
        keep_vec = q.status & ~clr_vec;
    end

    // Next state of the bank
    always_comb begin
        d = q;
        // Bus handshake: one wait cycle, then a one-cycle answer
        if ((avs_read_i || avs_write_i) && q.waitrequest) begin
            d.waitrequest = 1'b0;
            d.rdata = rd_mux;
        end else begin
            d.waitrequest = 1'b1;
        end
        // Register writes; reserved positions dropped by the field picks
        if (wr_fire) begin
            if (addr == pgc_pkg::OFF_GLOBAL) begin
                d.tx_drop = merged[pgc_pkg::TX_FRAG_BIT];
                d.rx_drop = merged[pgc_pkg::RX_FRAG_BIT];
                d.spoof_sel = merged[pgc_pkg::SPOOF_LSB +: pgc_pkg::NUM_SPOOF];
            end
            if (addr == pgc_pkg::OFF_SEED) begin
                // No interlock with redirection; firmware keeps it off
                d.seed = merged;
            end
            if (addr == pgc_pkg::OFF_MASK) begin
                d.mask = merged;
            end
            if (in_cfg) begin
                d.slot_cfg[slot_idx] = wd_cfg;
            end
        end
        // New events win over a clear in the same cycle
        d.status = keep_vec | hits;
        d.irq = |(d.status & d.mask);
        // Fragment class blocking
        d.verdict.tx_block = tx_pkt_i.valid && tx_pkt_i.fragment && q.tx_drop;
        d.verdict.rx_block = rx_pkt_i.valid && rx_pkt_i.fragment && q.rx_drop;
        // Spoof check only armed while some filter is selected
        d.verdict.spoof = tx_pkt_i.valid && (q.spoof_sel != 5'h00)
            && ((tx_pkt_i.src_match & q.spoof_sel) == 5'h00);
    end

    // State register with synchronous reset
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            q <= '0;
            q.seed <= pgc_pkg::SEED_RESET;
            q.spoof_sel <= pgc_pkg::SPOOF_RESET;
            q.waitrequest <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign avs_readdata_o = q.rdata;
    assign avs_waitrequest_o = q.waitrequest;
    assign verdict_o = q.verdict;
    assign hash_seed_o = q.seed;
    assign irq_o = q.irq;

    // Checks below watch only what this bank drives. They sample the same
    // nets as the logic above, so a broken decode shows up at the edge
    // after the request rather than much later on a software readback.
    // Limitation: the seed has no interlock against header redirection;
    // firmware must keep redirection off while it rewrites the seed.
    // Trade-off: one wait cycle on every access buys a registered read
    // mux, so the long slot readback path never reaches the bus outputs.
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    // Write that lands on this edge
    sequence s_wr_land;
        avs_write_i && !avs_waitrequest_o;
    endsequence

    // Fragmented transmit packet offered this cycle
    sequence s_tx_frag;
        tx_pkt_i.valid && tx_pkt_i.fragment;
    endsequence

    // Fragmented receive packet offered this cycle
    sequence s_rx_frag;
        rx_pkt_i.valid && rx_pkt_i.fragment;
    endsequence

    // Request held while waiting, answered the next edge
    sequence s_req;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_answer;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence

    a_bus_answer: assert property (s_req |=> s_answer)
        else $error("bus answer not one cycle after request");
    a_tx_frag_drop: assert property ((tx_pkt_i.valid && tx_pkt_i.fragment)
        |=> verdict_o.tx_block == $past(q.tx_drop))
        else $error("tx fragment verdict wrong");
    a_rx_frag_drop: assert property ((rx_pkt_i.valid && rx_pkt_i.fragment)
        |=> verdict_o.rx_block == $past(q.rx_drop))
        else $error("rx fragment verdict wrong");
    a_spoof_flag: assert property ((tx_pkt_i.valid && q.spoof_sel != 5'h00
        && (tx_pkt_i.src_match & q.spoof_sel) == 5'h00) |=> verdict_o.spoof)
        else $error("spoofed packet not flagged");
    a_reset_values: assert property ($fell(reset_i) |-> q.spoof_sel == 5'h00
        && hash_seed_o == 32'h0000_00ff)
        else $error("reset values wrong");
    a_status_sticky: assert property (1'b1 |=> ($past(keep_vec) & ~q.status) == 32'h0)
        else $error("status bit lost without clear");
    a_status_set: assert property ((hits != 32'h0) |=> (q.status & $past(hits)) == $past(hits))
        else $error("threshold event not recorded");
    a_irq_level: assert property (irq_o == |(q.status & q.mask))
        else $error("irq does not follow masked status");
    a_cfg_reserved: assert property ((!avs_waitrequest_o && $past(avs_read_i && in_cfg))
        |-> (avs_readdata_o & ~pgc_pkg::CNT_CFG_BITS) == 32'h0)
        else $error("reserved slot config bits not zero");
    a_cfg_write: assert property ((wr_fire && in_cfg)
        |=> q.slot_cfg[$past(slot_idx)] == $past(wd_cfg))
        else $error("slot config write lost");

    // Seed takes the merged word on the landing edge
    a_seed_write: assert property ((wr_fire && addr == pgc_pkg::OFF_SEED)
        |=> hash_seed_o == $past(merged))
        else $error("seed write lost");

    // Seed keeps its value without a write
    a_seed_hold: assert property (!(wr_fire && addr == pgc_pkg::OFF_SEED)
        |=> $stable(hash_seed_o))
        else $error("seed changed without write");

    // Global fields only move on a global write
    a_global_hold: assert property (!(wr_fire && addr == pgc_pkg::OFF_GLOBAL)
        |=> $stable(q.spoof_sel) && $stable(q.tx_drop) && $stable(q.rx_drop))
        else $error("global config changed without write");

    // Mask register takes the merged word
    a_mask_write: assert property ((wr_fire && addr == pgc_pkg::OFF_MASK)
        |=> q.mask == $past(merged))
        else $error("mask write lost");

    // A one written clears the bit when no event competes
    a_status_clear: assert property ((wr_fire && addr == pgc_pkg::OFF_STATUS
        && hits == 32'h0) |=> (q.status & $past(clr_vec)) == 32'h0)
        else $error("status bit not cleared by one");

    // Landing write must come from a real write request
    a_write_lands: assert property (s_wr_land |-> wr_fire)
        else $error("write answered but not applied");

    // Read data is the word addressed when the request was taken
    a_read_data: assert property ((avs_read_i && avs_waitrequest_o)
        |=> avs_readdata_o == $past(rd_mux))
        else $error("read data not the addressed word");

    // Idle bus never sees an answer
    a_idle_quiet: assert property ((!avs_read_i && !avs_write_i && avs_waitrequest_o)
        |=> avs_waitrequest_o)
        else $error("answer without request");

    // No transmit block without a fragment
    a_tx_frag_only: assert property (not s_tx_frag |=> !verdict_o.tx_block)
        else $error("tx block without fragment");

    // No receive block without a fragment
    a_rx_frag_only: assert property (not s_rx_frag |=> !verdict_o.rx_block)
        else $error("rx block without fragment");

    // Blocks follow the drop bit for fragments
    a_tx_frag_seq: assert property (s_tx_frag |=> verdict_o.tx_block == $past(q.tx_drop))
        else $error("tx fragment block mismatch");
    a_rx_frag_seq: assert property (s_rx_frag |=> verdict_o.rx_block == $past(q.rx_drop))
        else $error("rx fragment block mismatch");

    // Matched or disarmed packets are never flagged
    a_spoof_quiet: assert property ((!tx_pkt_i.valid || q.spoof_sel == 5'h00
        || (tx_pkt_i.src_match & q.spoof_sel) != 5'h00) |=> !verdict_o.spoof)
        else $error("spoof flag on a clean packet");

    // Slot bindings only move on a slot config write
    a_cfg_hold: assert property (!(wr_fire && in_cfg) |=> $stable(q.slot_cfg))
        else $error("slot config changed without write");
endmodule // pgc_top
`default_nettype wire

// [sim/pgc_tb_top.sv]
`default_nettype none
module pgc_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // Clock, reset and bus master signals
    logic sys_clk;
    logic reset;
    logic [13:0] addr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [3:0] be; // Byte lanes, full word unless a test narrows them
    logic [31:0] rdata;
    logic wait_rq;
    // Packet side stimulus and outputs
    pgc_pkg::pgc_tx_pkt_t tx_pkt;
    pgc_pkg::pgc_rx_pkt_t rx_pkt;
    logic [31:0] tx_match;
    logic [31:0] rx_match;
    pgc_pkg::pgc_verdict_t verdict;
    logic [31:0] seed_out;
    logic irq;
    // Score keeping
    int mismatches;
    int tests_run;
    logic [31:0] q;
    // Spoof table: select field and source match pattern
    logic [4:0] sel_tab [5] = '{5'h05, 5'h05, 5'h10, 5'h10, 5'h00};
    logic [4:0] src_tab [5] = '{5'h04, 5'h02, 5'h10, 5'h0f, 5'h00};

    pgc_top uut (
        .sys_clk_i(sys_clk), .reset_i(reset),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wait_rq),
        .tx_pkt_i(tx_pkt), .rx_pkt_i(rx_pkt),
        .tx_match_i(tx_match), .rx_match_i(rx_match),
        .verdict_o(verdict), .hash_seed_o(seed_out), .irq_o(irq)
    );

    // Free running 200 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Compare one value; case inequality so unknowns fail
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One Avalon cycle; request held until waitrequest sampled low
    task automatic bus(input logic is_wr, input logic [13:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        rd <= !is_wr;
        wr <= is_wr;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wait_rq !== 1'b0 && n < 50);
        // Bounded wait, a dead slave counts against the run
        if (n >= 50) begin
            mismatches++;
            $display("[ERR] bus ack expected 0 seen %b", wait_rq);
        end
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wr32(input logic [13:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd_chk(input string what, input logic [13:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(what, q, exp);
    endtask

    // One-cycle packet and match pulse, then let the verdict land
    task automatic pulse(input pgc_pkg::pgc_tx_pkt_t t, input pgc_pkg::pgc_rx_pkt_t r,
                         input logic [31:0] tm, input logic [31:0] rm);
        @(posedge sys_clk);
        tx_pkt <= t;
        rx_pkt <= r;
        tx_match <= tm;
        rx_match <= rm;
        @(posedge sys_clk);
        tx_pkt <= '0;
        rx_pkt <= '0;
        tx_match <= 32'h0;
        rx_match <= 32'h0;
        #1;
    endtask

    // Single ending point for normal end and watchdog
    task automatic wrap_up;
        $display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        mismatches++;
        $display("[ERR] watchdog expected done seen running");
        wrap_up();
    end

    // Main sequence
    initial begin
        reset = 1'b1;
        addr = 14'h0000;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0;
        be = 4'hf;
        tx_pkt = '0;
        rx_pkt = '0;
        tx_match = 32'h0;
        rx_match = 32'h0;
        mismatches = 0;
        tests_run = 0;
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        // Reset values
        rd_chk("global", pgc_pkg::OFF_GLOBAL, 32'h0);
        rd_chk("seed", pgc_pkg::OFF_SEED, 32'h0000_00ff);
        check("seed_out", seed_out, 32'h0000_00ff);
        rd_chk("status", pgc_pkg::OFF_STATUS, 32'h0);
        rd_chk("cfg31", pgc_pkg::OFF_CNT_CFG + 14'h00f8, 32'h0);
        $display("test reset done");
        // Field masks, reserved bits and unmapped places
        wr32(pgc_pkg::OFF_GLOBAL, 32'hffff_ffff);
        rd_chk("global", pgc_pkg::OFF_GLOBAL, 32'h1f00_1800);
        wr32(pgc_pkg::OFF_SEED, 32'h1234_5678);
        rd_chk("seed", pgc_pkg::OFF_SEED, 32'h1234_5678);
        check("seed_out", seed_out, 32'h1234_5678);
        be <= 4'h1;
        wr32(pgc_pkg::OFF_SEED, 32'haaaa_aaaa);
        be <= 4'hf;
        rd_chk("seed_lane", pgc_pkg::OFF_SEED, 32'h1234_56aa);
        wr32(pgc_pkg::OFF_CNT_CFG + 14'h00f8, 32'hffff_ffff);
        rd_chk("cfg31", pgc_pkg::OFF_CNT_CFG + 14'h00f8, 32'h0000_1003);
        wr32(14'h1204, 32'hffff_ffff);
        rd_chk("odd_slot", 14'h1204, 32'h0);
        rd_chk("unmapped", 14'h0004, 32'h0);
        $display("test registers done");
        // All four drop settings, fragmented and plain packets
        for (int k = 0; k < 4; k++) begin
            wr32(pgc_pkg::OFF_GLOBAL, 32'(k) << 11);
            pulse({1'b1, 1'b1, 5'h00}, {1'b1, 1'b1}, 32'h0, 32'h0);
            check("frag_verdict", {29'h0, verdict}, {29'h0, k[0], k[1], 1'b0});
            pulse({1'b1, 1'b0, 5'h00}, {1'b1, 1'b0}, 32'h0, 32'h0);
            check("plain_verdict", {29'h0, verdict}, 32'h0);
        end
        $display("test fragments done");
        // Spoof table, bit order of the select field
        for (int k = 0; k < 5; k++) begin
            wr32(pgc_pkg::OFF_GLOBAL, {3'h0, sel_tab[k], 24'h0});
            pulse({1'b1, 1'b0, src_tab[k]}, 2'b00, 32'h0, 32'h0);
            check("spoof", {31'h0, verdict.spoof},
                  {31'h0, (sel_tab[k] != 5'h00) && ((sel_tab[k] & src_tab[k]) == 5'h00)});
        end
        $display("test spoof done");
        // Slot 5 bound to transmit filter 4, threshold 3
        wr32(pgc_pkg::OFF_GLOBAL, 32'h0);
        wr32(pgc_pkg::OFF_CNT_CFG + 14'h0028, 32'h0000_0003);
        wr32(pgc_pkg::OFF_CNT_VAL + 14'h0028, 32'h0003_0000);
        wr32(pgc_pkg::OFF_MASK, 32'h0000_0020);
        pulse('0, '0, 32'h0000_0020, 32'h0000_0010);
        rd_chk("wrong_filter", pgc_pkg::OFF_CNT_VAL + 14'h0028, 32'h0003_0000);
        pulse('0, '0, 32'h0000_0010, 32'h0);
        pulse('0, '0, 32'h0000_0010, 32'h0);
        rd_chk("count2", pgc_pkg::OFF_CNT_VAL + 14'h0028, 32'h0003_0002);
        check("irq_low", {31'h0, irq}, 32'h0);
        pulse('0, '0, 32'h0000_0010, 32'h0);
        repeat (2) @(posedge sys_clk);
        #1;
        check("irq_hit", {31'h0, irq}, 32'h1);
        rd_chk("wrapped", pgc_pkg::OFF_CNT_VAL + 14'h0028, 32'h0003_0000);
        rd_chk("status", pgc_pkg::OFF_STATUS, 32'h0000_0020);
        wr32(pgc_pkg::OFF_STATUS, 32'hffff_ffdf);
        rd_chk("sticky", pgc_pkg::OFF_STATUS, 32'h0000_0020);
        wr32(pgc_pkg::OFF_STATUS, 32'h0000_0020);
        rd_chk("cleared", pgc_pkg::OFF_STATUS, 32'h0);
        check("irq_clr", {31'h0, irq}, 32'h0);
        // Low index bit moves the binding to filter 5
        wr32(pgc_pkg::OFF_CNT_CFG + 14'h0028, 32'h0000_1003);
        pulse('0, '0, 32'h0000_0020, 32'h0);
        rd_chk("fn_bit", pgc_pkg::OFF_CNT_VAL + 14'h0028, 32'h0003_0001);
        $display("test counter done");
        // Slot 7 disabled, then enabled on receive filter 6
        wr32(pgc_pkg::OFF_CNT_VAL + 14'h0038, 32'h0001_0000);
        pulse('0, '0, 32'h0000_0040, 32'h0000_0040);
        repeat (2) @(posedge sys_clk);
        rd_chk("disabled", pgc_pkg::OFF_CNT_VAL + 14'h0038, 32'h0001_0000);
        rd_chk("dis_status", pgc_pkg::OFF_STATUS, 32'h0);
        wr32(pgc_pkg::OFF_CNT_CFG + 14'h0038, 32'h0000_0001);
        pulse('0, '0, 32'h0, 32'h0000_0040);
        repeat (2) @(posedge sys_clk);
        rd_chk("rx_status", pgc_pkg::OFF_STATUS, 32'h0000_0080);
        check("irq_masked", {31'h0, irq}, 32'h0);
        wr32(pgc_pkg::OFF_MASK, 32'h0000_0080);
        repeat (2) @(posedge sys_clk);
        check("irq_unmask", {31'h0, irq}, 32'h1);
        $display("test disabled done");
        wrap_up();
    end
endmodule // pgc_tb_top
`default_nettype wire
